//--- erlo_defines.vh
// Constants for the E1 receive line option block: register map, fields, resets, timing.
// Assumes a single 25 MHz clock and an AXI4-Lite register bus with 32-bit data.
`ifndef ERLO_DEFINES_VH
`define ERLO_DEFINES_VH
`define ERLO_OFS_LINE_OPT 12'h000
`define ERLO_OFS_MODE_SEL 12'h400
`define ERLO_OFS_CTRL 12'h404
`define ERLO_OFS_STATUS 12'h408
`define ERLO_OFS_FER_COUNT 12'h40c
`define ERLO_RST_LINE_OPT 8'h00
`define ERLO_RST_MODE_SEL 8'h01
`define ERLO_RST_CTRL 8'h00
`define ERLO_BIT_FIFO_BYPASS 7
`define ERLO_BIT_FREEZE 6
`define ERLO_BIT_WORD_MODE 5
`define ERLO_BIT_NFAS_CHECK 4
`define ERLO_BIT_AUTO_RAI 3
`define ERLO_BIT_AUTO_RED 2
`define ERLO_BIT_AUTO_OOF 1
`define ERLO_BIT_AUTO_LATCH 0
`define ERLO_BIT_RAI_FORCE 0
`define ERLO_BIT_RAI_SELECT 1
`define ERLO_BIT_LATCH_REQ 2
`define ERLO_FIFO_DELAY_BITS 24
`define ERLO_SECOND_NS 1000000000
`define ERLO_CLOCK_NS 40
`define ERLO_SECOND_CYCLES (`ERLO_SECOND_NS / `ERLO_CLOCK_NS)
// Last count of the one-second divider, sized to the 25-bit counter so the compare is width-exact
`define ERLO_SECOND_LAST 25'd24999999
`endif

//--- erlo_delay_line.v
// Fixed delay line standing in for the receive jitter attenuation FIFO path.
// Assumes data and strobe arrive on the system clock.
`timescale 1ns/1ps
`include "erlo_defines.vh"
module erlo_delay_line
(
  input wire clk,
  input wire nrst,
  input wire bit_in,
  input wire strobe,
  output wire bit_out
);
  reg [`ERLO_FIFO_DELAY_BITS-1:0] shift_reg;
  // Shift only on line bit strobes so the delay is counted in bits
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      shift_reg <= 24'h000000;
    else if (strobe)
      shift_reg <= {shift_reg[`ERLO_FIFO_DELAY_BITS-2:0], bit_in};
  end
  assign bit_out = shift_reg[`ERLO_FIFO_DELAY_BITS-1];
endmodule // erlo_delay_line

//--- erlo_line_options.v
// E1 receive line options: register bank, error counting, alarm and conditioning control.
// Assumes framer status and line data arrive as pins, synchronised here; AXI4-Lite slave.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "erlo_defines.vh"
module erlo_line_options
(
  input wire CLOCK,
  input wire NRST,
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire RX_BIT_IN,
  input wire RX_BIT_STROBE,
  input wire FAS_BIT_ERR,
  input wire FAS_WORD_END,
  input wire NFAS_BIT2,
  input wire NFAS_BIT2_STROBE,
  input wire RED_ALARM,
  input wire OUT_OF_FRAME,
  input wire AIS_DETECT,
  input wire TRUNK_CODE_BIT,
  output reg RX_SYSTEM_DATA,
  output wire LINE_STANDARD_SELECT,
  output wire FRAME_SEARCH_ENABLE,
  output wire SIGNALING_FREEZE,
  output wire TRUNK_CONDITIONING,
  output wire REMOTE_ALARM_INDICATION,
  output reg COUNTER_LATCH
);
  reg [7:0] line_opt_reg;
  reg [7:0] mode_reg;
  reg [7:0] ctrl_reg;
  reg [15:0] fer_count_reg;
  reg [15:0] fer_count_next;
  reg [15:0] fer_latched_reg;
  reg word_err_reg;
  reg word_pending_reg;
  reg [24:0] second_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [11:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg host_latch_req;
  wire rx_bit_s;
  wire rx_strobe_s;
  wire fas_err_s;
  wire fas_end_s;
  wire nfas_bit_s;
  wire nfas_strobe_s;
  wire red_s;
  wire oof_s;
  wire ais_s;
  wire trunk_s;
  wire fifo_out;
  wire [9:0] pin_raw;
  wire [9:0] pin_sync;
  wire do_write;
  wire second_tick;
  wire oof_effective;
  wire word_mode;
  wire nfas_check;

  // Every framer and line pin level crosses two flip-flops before use
  assign pin_raw = {RX_BIT_IN, RX_BIT_STROBE, FAS_BIT_ERR, FAS_WORD_END, NFAS_BIT2,
                    NFAS_BIT2_STROBE, RED_ALARM, OUT_OF_FRAME, AIS_DETECT, TRUNK_CODE_BIT};
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_sync
      erlo_sync u_sync
      (
        .clk(CLOCK),
        .nrst(NRST),
        .d(pin_raw[gi]),
        .q(pin_sync[gi])
      );
    end
  endgenerate
  assign {rx_bit_s, rx_strobe_s, fas_err_s, fas_end_s, nfas_bit_s,
          nfas_strobe_s, red_s, oof_s, ais_s, trunk_s} = pin_sync;

  // AXI write channels: address and data latched independently, either order
  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        case ({aw_addr_reg[11:2], 2'b00})
          `ERLO_OFS_LINE_OPT, `ERLO_OFS_MODE_SEL, `ERLO_OFS_CTRL, `ERLO_OFS_STATUS, `ERLO_OFS_FER_COUNT:
            bresp_reg <= 2'h0;
          default:
            bresp_reg <= 2'h2; // Unmapped address answers SLVERR
        endcase
      end
      else if (bvalid_reg && S_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // Register file; only byte lane 0 carries data
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      line_opt_reg <= `ERLO_RST_LINE_OPT;
      mode_reg <= `ERLO_RST_MODE_SEL;
      ctrl_reg <= `ERLO_RST_CTRL;
      host_latch_req <= 1'b0;
    end
    else
    begin
      host_latch_req <= 1'b0;
      if (do_write && w_strb_reg[0])
      begin
        case ({aw_addr_reg[11:2], 2'b00})
          `ERLO_OFS_LINE_OPT:
            line_opt_reg <= w_data_reg[7:0];
          `ERLO_OFS_MODE_SEL:
            mode_reg <= {7'h00, w_data_reg[0]}; // Upper bits reserved
          `ERLO_OFS_CTRL:
          begin
            ctrl_reg <= {6'h00, w_data_reg[1:0]};
            host_latch_req <= w_data_reg[`ERLO_BIT_LATCH_REQ]; // Self-clearing request
          end
          default:
            ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end
  assign LINE_STANDARD_SELECT = mode_reg[0];

  // Read path
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  always @*
  begin
    rd_ok = 1'b1;
    case ({S_AXI_ARADDR[11:2], 2'b00})
      `ERLO_OFS_LINE_OPT: rd_mux = {24'h000000, line_opt_reg};
      `ERLO_OFS_MODE_SEL: rd_mux = {24'h000000, mode_reg};
      `ERLO_OFS_CTRL: rd_mux = {24'h000000, ctrl_reg};
      `ERLO_OFS_STATUS: rd_mux = {27'h0000000, TRUNK_CONDITIONING, REMOTE_ALARM_INDICATION,
                                  oof_s, red_s, ais_s};
      `ERLO_OFS_FER_COUNT: rd_mux = {16'h0000, fer_latched_reg};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end
    else if (S_AXI_ARVALID && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (rvalid_reg && S_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

  // Jitter FIFO path or its bypass
  erlo_delay_line u_fifo
  (
    .clk(CLOCK),
    .nrst(NRST),
    .bit_in(rx_bit_s),
    .strobe(rx_strobe_s),
    .bit_out(fifo_out)
  );

  // Freeze forces out-of-frame as seen by conditioning
  assign FRAME_SEARCH_ENABLE = !line_opt_reg[`ERLO_BIT_FREEZE];
  assign SIGNALING_FREEZE = line_opt_reg[`ERLO_BIT_FREEZE];
  assign oof_effective = oof_s || line_opt_reg[`ERLO_BIT_FREEZE];
  assign TRUNK_CONDITIONING = (line_opt_reg[`ERLO_BIT_AUTO_RED] && red_s) ||
                              (line_opt_reg[`ERLO_BIT_AUTO_OOF] && oof_effective);

  // System data: trunk code while conditioned, else payload unchanged
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      RX_SYSTEM_DATA <= 1'b0;
    else if (TRUNK_CONDITIONING)
      RX_SYSTEM_DATA <= trunk_s;
    else if (line_opt_reg[`ERLO_BIT_FIFO_BYPASS])
      RX_SYSTEM_DATA <= rx_bit_s; // Skips 24-bit delay
    else
      RX_SYSTEM_DATA <= fifo_out;
  end

  // Remote alarm: select 1 sends on frame loss only, 0 on frame loss or AIS
  assign REMOTE_ALARM_INDICATION = line_opt_reg[`ERLO_BIT_AUTO_RAI] ?
    (oof_s || (!ctrl_reg[`ERLO_BIT_RAI_SELECT] && ais_s)) :
    ctrl_reg[`ERLO_BIT_RAI_FORCE];

  // Framing bit error counting per the two mode bits
  assign word_mode = line_opt_reg[`ERLO_BIT_WORD_MODE];
  assign nfas_check = line_opt_reg[`ERLO_BIT_NFAS_CHECK];
  always @*
  begin
    fer_count_next = fer_count_reg;
    if (fas_err_s && !word_mode)
      fer_count_next = fer_count_next + 16'h0001; // Each bit singly
    if (fas_end_s && word_mode && !nfas_check && (word_err_reg || fas_err_s))
      fer_count_next = fer_count_next + 16'h0001; // One per pattern
    if (nfas_strobe_s && !word_mode && nfas_check && !nfas_bit_s)
      fer_count_next = fer_count_next + 16'h0001; // Zero in NFAS bit two
    if (nfas_strobe_s && word_mode && nfas_check && word_pending_reg && (word_err_reg || !nfas_bit_s))
      fer_count_next = fer_count_next + 16'h0001; // One per 8-bit word
  end
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      word_err_reg <= 1'b0;
      word_pending_reg <= 1'b0;
      fer_count_reg <= 16'h0000;
    end
    else
    begin
      fer_count_reg <= COUNTER_LATCH ? 16'h0000 : fer_count_next;
      // Error accumulates over a pattern; kept until NFAS bit two in 8-bit mode
      if (fas_end_s)
      begin
        word_err_reg <= (word_mode && nfas_check) ? (word_err_reg || fas_err_s) : 1'b0;
        word_pending_reg <= word_mode && nfas_check;
      end
      else if (nfas_strobe_s && word_pending_reg)
      begin
        word_err_reg <= 1'b0;
        word_pending_reg <= 1'b0;
      end
      else if (fas_err_s)
        word_err_reg <= 1'b1;
    end
  end

  // One-second tick and counter latch; a latch clears the running count
  assign second_tick = (second_reg == `ERLO_SECOND_LAST);
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      second_reg <= 25'h0000000;
      COUNTER_LATCH <= 1'b0;
      fer_latched_reg <= 16'h0000;
    end
    else
    begin
      second_reg <= second_tick ? 25'h0000000 : second_reg + 25'h0000001;
      COUNTER_LATCH <= (second_tick && line_opt_reg[`ERLO_BIT_AUTO_LATCH]) || host_latch_req;
      if (COUNTER_LATCH)
        fer_latched_reg <= fer_count_next;
    end
  end
endmodule // erlo_line_options

//--- erlo_line_options_properties.sv
// Port-level checker for the E1 receive line option block.
// Assumes it is bound to erlo_line_options and shares its single clock.
`timescale 1ns/1ps
module erlo_props
(
  input wire CLOCK,
  input wire NRST,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_RVALID,
  input wire RED_ALARM,
  input wire OUT_OF_FRAME,
  input wire AIS_DETECT,
  input wire TRUNK_CODE_BIT,
  input wire RX_SYSTEM_DATA,
  input wire LINE_STANDARD_SELECT,
  input wire FRAME_SEARCH_ENABLE,
  input wire SIGNALING_FREEZE,
  input wire TRUNK_CONDITIONING,
  input wire REMOTE_ALARM_INDICATION,
  input wire COUNTER_LATCH
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // Status pins reach the outputs through two sync flops, so causes are looked up two edges back
  freeze_pair_a: assert property (FRAME_SEARCH_ENABLE != SIGNALING_FREEZE)
    else $error("freeze outputs disagree");
  std_change_a: assert property ($changed(LINE_STANDARD_SELECT) |-> S_AXI_BVALID)
    else $error("standard select moved without a write");
  trunk_rise_a: assert property ($rose(TRUNK_CONDITIONING) |-> S_AXI_BVALID || $past(RED_ALARM, 2)
    || $past(OUT_OF_FRAME, 2)) else $error("conditioning started without cause");
  trunk_fall_a: assert property ($fell(TRUNK_CONDITIONING) |-> S_AXI_BVALID || !$past(RED_ALARM, 2)
    || !$past(OUT_OF_FRAME, 2)) else $error("conditioning ended without cause");
  trunk_data_a: assert property (TRUNK_CONDITIONING |=> RX_SYSTEM_DATA == $past(TRUNK_CODE_BIT, 3))
    else $error("system data is not the trunk code");
  rai_rise_a: assert property ($rose(REMOTE_ALARM_INDICATION) |-> S_AXI_BVALID || $past(OUT_OF_FRAME, 2)
    || $past(AIS_DETECT, 2)) else $error("remote alarm raised without cause");
  latch_pulse_a: assert property (COUNTER_LATCH |=> !COUNTER_LATCH)
    else $error("counter latch longer than one cycle");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
endmodule // erlo_props

bind erlo_line_options erlo_props erlo_props_i
(
  .CLOCK(CLOCK),
  .NRST(NRST),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_RVALID(S_AXI_RVALID),
  .RED_ALARM(RED_ALARM),
  .OUT_OF_FRAME(OUT_OF_FRAME),
  .AIS_DETECT(AIS_DETECT),
  .TRUNK_CODE_BIT(TRUNK_CODE_BIT),
  .RX_SYSTEM_DATA(RX_SYSTEM_DATA),
  .LINE_STANDARD_SELECT(LINE_STANDARD_SELECT),
  .FRAME_SEARCH_ENABLE(FRAME_SEARCH_ENABLE),
  .SIGNALING_FREEZE(SIGNALING_FREEZE),
  .TRUNK_CONDITIONING(TRUNK_CONDITIONING),
  .REMOTE_ALARM_INDICATION(REMOTE_ALARM_INDICATION),
  .COUNTER_LATCH(COUNTER_LATCH)
);

//--- erlo_sync.v
// Two-flop synchroniser for a level arriving from a pin.
// Assumes the destination is the system clock.
`timescale 1ns/1ps
module erlo_sync
(
  input wire clk,
  input wire nrst,
  input wire d,
  output wire q
);
  reg meta_reg;
  reg sync_reg;
  // First stage feeds only the second stage
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // erlo_sync

//--- tb_e1_receive_line_options.sv
// Self-checking bench for the E1 receive line option block.
// Assumes erlo_line_options and its checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_e1_receive_line_options;
  reg clock = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  reg [11:0] awa = 12'h000, ara = 12'h000;
  reg [31:0] wd = 32'h0, rd, e;
  reg [2:0] ev = 3'h0, st = 3'h0;
  reg rxb = 1'b0, rxs = 1'b0, nb2 = 1'b0, tk = 1'b0;
  reg [1:0] rr;
  wire awr, wr_rdy, bv, arr, rv, rsd, lss, fse, sfz, trk, remote_alarm_indication, cl;
  wire [1:0] br, rresp;
  wire [31:0] rdata;
  integer num_errors = 0, comparisons = 0, m;
  erlo_line_options dut (.CLOCK(clock), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .RX_BIT_IN(rxb),
    .RX_BIT_STROBE(rxs), .FAS_BIT_ERR(ev[2]), .FAS_WORD_END(ev[1]), .NFAS_BIT2(nb2), .NFAS_BIT2_STROBE(ev[0]),
    .RED_ALARM(st[2]), .OUT_OF_FRAME(st[1]), .AIS_DETECT(st[0]), .TRUNK_CODE_BIT(tk), .RX_SYSTEM_DATA(rsd),
    .LINE_STANDARD_SELECT(lss), .FRAME_SEARCH_ENABLE(fse), .SIGNALING_FREEZE(sfz), .TRUNK_CONDITIONING(trk),
    .REMOTE_ALARM_INDICATION(remote_alarm_indication), .COUNTER_LATCH(cl));
  // Clock at 25 MHz
  always #20 clock = ~clock;
  task end_of_test;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Handshakes are judged at the falling edge so ready values have settled
  task wr(input [11:0] a, input [31:0] d);
    reg t, ta, tw;
    begin
      @(posedge clock);
      {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
      t = 1'b0;
      while (!t)
      begin
        @(negedge clock);
        {ta, tw, t} = {awr, wr_rdy, bv};
        @(posedge clock);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        if (t) bre <= 1'b0;
      end
    end
  endtask
  task rdr(input [11:0] a);
    reg t, ta;
    begin
      @(posedge clock);
      {ara, arv, rre} <= {a, 2'h3};
      t = 1'b0;
      while (!t)
      begin
        @(negedge clock);
        {ta, t, rd, rr} = {arr, rv, rdata, rresp};
        @(posedge clock);
        if (ta) arv <= 1'b0;
        if (t) rre <= 1'b0;
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // One framer event pulse, then a gap so the sync flops see it once
  task pl(input [2:0] v, input b);
    begin
      @(posedge clock) {ev, nb2} <= {v, b};
      @(posedge clock) ev <= 3'h0;
      repeat (2) @(posedge clock);
    end
  endtask
  task stb(input integer n);
    repeat (n)
    begin
      @(posedge clock) rxs <= 1'b1;
      @(posedge clock) rxs <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      rdr(12'h000); `CHK(rd, 32'h0)
      rdr(12'h400); `CHK(rd, 32'h1)
      `CHK(lss, 1'b1)
      wr(12'h400, 32'h0); rdr(12'h400); `CHK(rd, 32'h0)
      `CHK(lss, 1'b0)
      rdr(12'h010); `CHK(rr, 2'b10)
      wr(12'h000, 32'hff); rdr(12'h000); `CHK(rd, 32'hff)
      wr(12'h000, 32'h40); `CHK(({fse, sfz, trk}), 3'b010)
      wr(12'h000, 32'h42); `CHK(trk, 1'b1)
      wr(12'h000, 32'h0); `CHK(({fse, sfz, trk}), 3'b100)
    end
  endtask
  task t_cond;
    begin
      @(posedge clock) {st, tk} <= 4'hd;
      idle(4); `CHK(trk, 1'b0)
      wr(12'h000, 32'h04); idle(2); `CHK(({trk, rsd}), 2'b11)
      wr(12'h000, 32'h02); `CHK(trk, 1'b1)
      @(posedge clock) st <= 3'h0;
      idle(4); `CHK(({trk, rsd}), 2'b00)
    end
  endtask
  // Jitter FIFO depth: the first line bit must not show before about 24 bits
  task t_fifo;
    begin
      @(posedge clock) rxb <= 1'b1;
      stb(20); idle(4); `CHK(rsd, 1'b0)
      stb(8); idle(4); `CHK(rsd, 1'b1)
      @(posedge clock) rxb <= 1'b0;
      idle(4); `CHK(rsd, 1'b1)
      wr(12'h000, 32'h80); idle(4); `CHK(rsd, 1'b0)
    end
  endtask
  task t_count;
    for (m = 0; m < 4; m++)
    begin
      e = (m == 0) ? 32'h3 : (m == 1) ? 32'h4 : (m == 2) ? 32'h1 : 32'h2;
      wr(12'h000, m << 4);
      wr(12'h404, 32'h4);
      pl(3'h4, 1'b1); pl(3'h4, 1'b1); pl(3'h6, 1'b1); pl(3'h1, 1'b1);
      pl(3'h2, 1'b1); pl(3'h1, 1'b0);
      wr(12'h404, 32'h4); idle(1); `CHK(cl, 1'b1)
      rdr(12'h40c); `CHK(rd, e)
      `CHK(cl, 1'b0)
    end
  endtask
  task t_alarm;
    begin
      wr(12'h000, 32'h0);
      @(posedge clock) st <= 3'h3;
      idle(4); `CHK(remote_alarm_indication, 1'b0)
      wr(12'h404, 32'h1); `CHK(remote_alarm_indication, 1'b1)
      wr(12'h404, 32'h0); wr(12'h000, 32'h08); `CHK(remote_alarm_indication, 1'b1)
      @(posedge clock) st <= 3'h1;
      idle(4); `CHK(remote_alarm_indication, 1'b1)
      wr(12'h404, 32'h2); `CHK(remote_alarm_indication, 1'b0)
      @(posedge clock) st <= 3'h2;
      idle(4); `CHK(remote_alarm_indication, 1'b1)
      rdr(12'h408); `CHK(rd, 32'hc)
    end
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_cond;
    t_fifo;
    t_count;
    t_alarm;
    end_of_test;
  end
  // Watchdog at 10000 cycles, far beyond the few hundred cycles the scenarios need
  initial
  begin
    #400000;
    num_errors++;
    end_of_test;
  end
endmodule // tb_e1_receive_line_options
